// >>> verilog/rtc_alarm_pkg.sv
// Purpose: shared constants and types for the alarm, wave and output block
// Assumes: byte-wide register port fed by the serial protocol engine
// Notes:   register index equals the pointer value presented by that engine
package rtc_alarm_pkg;

    // ------------------------------------------------------------
    // register locations
    // ------------------------------------------------------------
    localparam logic [7:0] SECONDS_ADDR       = 8'h01;
    localparam logic [7:0] CENTURY_HOURS_ADDR = 8'h03;
    localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h08;
    localparam logic [7:0] FIXED_OUT_ADDR     = 8'h09;
    localparam logic [7:0] ALARM_MONTH_ADDR   = 8'h0A;
    localparam logic [7:0] ALARM_DATE_ADDR    = 8'h0B;
    localparam logic [7:0] ALARM_HOUR_ADDR    = 8'h0C;
    localparam logic [7:0] ALARM_MIN_ADDR     = 8'h0D;
    localparam logic [7:0] ALARM_SEC_ADDR     = 8'h0E;
    localparam logic [7:0] FLAGS_ADDR         = 8'h0F;
    localparam logic [7:0] WAVE_ADDR          = 8'h13;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HALT_BIT        = 7;
    localparam int CENTURY_EN_BIT  = 7;
    localparam int CENTURY_BIT     = 6;
    localparam int OUT_LEVEL_BIT   = 7;
    localparam int FIXED_EN_BIT    = 7;
    localparam int IRQ_EN_BIT      = 7;
    localparam int SQW_EN_BIT      = 6;
    localparam int RPT_HI_BIT      = 7;
    localparam int RPT5_BIT        = 6;
    localparam int FLAG_BIT        = 6;
    localparam int RATE_LSB        = 4;

    // ------------------------------------------------------------
    // power-up values
    // ------------------------------------------------------------
    localparam logic       HALT_RST       = 1'b0;
    localparam logic       OUT_LEVEL_RST  = 1'b1;
    localparam logic       FIXED_EN_RST   = 1'b1;
    localparam logic [7:0] ALARM_REG_RST  = 8'h00;
    localparam logic [3:0] RATE_RST       = 4'h0;

    // ------------------------------------------------------------
    // repeat codes, alarm_repeat_bits
    // ------------------------------------------------------------
    localparam logic [4:0] RPT_SECOND = 5'h1F;
    localparam logic [4:0] RPT_MINUTE = 5'h1E;
    localparam logic [4:0] RPT_HOUR   = 5'h1C;
    localparam logic [4:0] RPT_DAY    = 5'h18;
    localparam logic [4:0] RPT_MONTH  = 5'h10;
    localparam logic [4:0] RPT_YEAR   = 5'h00;

    localparam int OSC_DIV_W = 15;

    // running calendar, bcd
    typedef struct packed {
        logic [4:0] month;
        logic [5:0] date;
        logic [5:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } cal_time_t;

    // open-drain pin: data and pull-down enable
    typedef struct packed {
        logic o;
        logic oe;
    } od_pin_t;

endpackage : rtc_alarm_pkg

// >>> verilog/rtc_alarm_sqw_output_logic.sv
// Purpose: alarm compare, flag, open-drain multi-function and 32 kHz outputs
// Assumes: protocol engine supplies pointer and read/write strobes; counters
//          supply the bcd calendar, an update pulse and a century pulse
// Notes:   osc_clk is sampled on clk; it must be well below clk / 4
//
// Notes on behaviour
// - alarm fields held at five consecutive locations
// - repeat bits choose which fields must match
// - undefined repeat codes behave as every second
// - matching time sets the alarm flag
// - flag with irq enable pulls pin low
// - pointer on flag register holds interrupt off
// - flag read clears flag and releases pin
// - rate code selects binary-divided wave frequency
// - 32 kHz output runs while oscillator runs
// - only enable bit or halt stops it
// - century flag toggles at rollover when enabled
// - otherwise pin follows output level bit
// - both outputs only pull low or release
// - reset sets power-up defaults of control bits
// - wave enable routes wave onto shared pin
// - host writes never change alarm flag
// - alarm fields stored as bcd
// - rate in upper nibble, lower reads zero
`timescale 1ns/10ps

module rtc_alarm_sqw_output_logic
    import rtc_alarm_pkg::*;
#(
    parameter int DIV_W = OSC_DIV_W
) (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      sys_rst,
    // oscillator timebase
    input  wire logic      osc_clk,
    // register port from the serial engine
    input  wire logic [7:0] reg_ptr,
    input  wire logic      reg_wr_stb,
    input  wire logic [7:0] reg_wdata,
    input  wire logic      reg_rd_stb,
    output logic     [7:0] reg_rdata,
    output logic           reg_rvalid,
    // calendar counters
    input  wire cal_time_t cur_time,
    input  wire logic      time_update,
    input  wire logic      century_rollover,
    // status to counters
    output logic           osc_halt,
    // open-drain pins
    output od_pin_t        multi_function_output,
    output od_pin_t        fixed_32k_output
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic       osc_halt_q;
    logic       century_toggle_enable_q;
    logic       century_flag_q;
    logic       output_level_bit_q;
    logic       fixed_output_enable_q;
    logic [7:0] alarm_q [5];
    logic [3:0] wave_rate_select_q;
    logic       alarm_match_flag_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    od_pin_t    mfo_q;
    od_pin_t    fixed_32k_output_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_sec   = reg_wr_stb && (reg_ptr == SECONDS_ADDR);
    wire logic wr_hours = reg_wr_stb && (reg_ptr == CENTURY_HOURS_ADDR);
    wire logic wr_ctl   = reg_wr_stb && (reg_ptr == OUTPUT_CONTROL_ADDR);
    wire logic wr_fix   = reg_wr_stb && (reg_ptr == FIXED_OUT_ADDR);
    wire logic wr_wave  = reg_wr_stb && (reg_ptr == WAVE_ADDR);
    wire logic rd_flags = reg_rd_stb && (reg_ptr == FLAGS_ADDR);

    wire logic       alarm_irq_enable   = alarm_q[0][IRQ_EN_BIT];
    wire logic       square_wave_enable = alarm_q[0][SQW_EN_BIT];
    wire logic [4:0] alarm_repeat_bits  = {alarm_q[1][RPT5_BIT], alarm_q[1][RPT_HI_BIT],
                                           alarm_q[2][RPT_HI_BIT], alarm_q[3][RPT_HI_BIT],
                                           alarm_q[4][RPT_HI_BIT]};

    // ------------------------------------------------------------
    // alarm settings
    // ------------------------------------------------------------
    // five alarm locations
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_alarm
            wire logic wr_hit = reg_wr_stb &&
                                (reg_ptr == ALARM_MONTH_ADDR + 8'(gi));
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    alarm_q[gi] <= ALARM_REG_RST;
                end else if (wr_hit) begin
                    alarm_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // alarm compare
    // ------------------------------------------------------------
    wire logic eq_mon  = (cur_time.month == alarm_q[0][4:0]);
    wire logic eq_date = (cur_time.date  == alarm_q[1][5:0]);
    wire logic eq_hour = (cur_time.hour  == alarm_q[2][5:0]);
    wire logic eq_min  = (cur_time.min   == alarm_q[3][6:0]);
    wire logic eq_sec  = (cur_time.sec   == alarm_q[4][6:0]);

    wire logic match_scope =
        (alarm_repeat_bits == RPT_MINUTE) ? eq_sec :
        (alarm_repeat_bits == RPT_HOUR)   ? (eq_min && eq_sec) :
        (alarm_repeat_bits == RPT_DAY)    ? (eq_hour && eq_min && eq_sec) :
        (alarm_repeat_bits == RPT_MONTH)  ? (eq_date && eq_hour && eq_min && eq_sec) :
        (alarm_repeat_bits == RPT_YEAR)   ? (eq_mon && eq_date && eq_hour &&
                                             eq_min && eq_sec) :
        1'b1;

    wire logic alarm_hit = time_update && match_scope;

    // host writes ignored
    // a match in the clearing cycle wins so no event is lost
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_match_flag_q <= 1'b0;
        end else if (alarm_hit) begin
            alarm_match_flag_q <= 1'b1;
        end else if (rd_flags) begin
            alarm_match_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    // century toggle on rollover
    wire logic century_flip = century_rollover && century_toggle_enable_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_halt_q            <= HALT_RST;
            output_level_bit_q    <= OUT_LEVEL_RST;
            fixed_output_enable_q <= FIXED_EN_RST;
            wave_rate_select_q    <= RATE_RST;
        end else begin
            if (wr_sec) begin
                osc_halt_q <= reg_wdata[HALT_BIT];
            end
            if (wr_ctl) begin
                output_level_bit_q <= reg_wdata[OUT_LEVEL_BIT];
            end
            if (wr_fix) begin
                fixed_output_enable_q <= reg_wdata[FIXED_EN_BIT];
            end
            if (wr_wave) begin
                wave_rate_select_q <= reg_wdata[RATE_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            century_toggle_enable_q <= 1'b0;
            century_flag_q          <= 1'b0;
        end else if (wr_hours) begin
            century_toggle_enable_q <= reg_wdata[CENTURY_EN_BIT];
            century_flag_q          <= reg_wdata[CENTURY_BIT] ^ century_flip;
        end else if (century_flip) begin
            century_flag_q <= ~century_flag_q;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (reg_ptr == SECONDS_ADDR) begin
            rd_mux = {osc_halt_q, cur_time.sec};
        end else if (reg_ptr == CENTURY_HOURS_ADDR) begin
            rd_mux = {century_toggle_enable_q, century_flag_q, cur_time.hour};
        end else if (reg_ptr == OUTPUT_CONTROL_ADDR) begin
            rd_mux = {output_level_bit_q, 7'h00};
        end else if (reg_ptr == FIXED_OUT_ADDR) begin
            rd_mux = {fixed_output_enable_q, 7'h00};
        end else if (reg_ptr >= ALARM_MONTH_ADDR && reg_ptr <= ALARM_SEC_ADDR) begin
            rd_mux = alarm_q[3'(reg_ptr - ALARM_MONTH_ADDR)];
        end else if (reg_ptr == FLAGS_ADDR) begin
            rd_mux = {1'b0, alarm_match_flag_q, 6'h00};
        end else if (reg_ptr == WAVE_ADDR) begin
            rd_mux = {wave_rate_select_q, 4'h0};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_stb;
            if (reg_rd_stb) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // oscillator sampling and divider
    // ------------------------------------------------------------
    logic [2:0]       osc_sync_q;
    logic             osc_lvl_q;
    logic [DIV_W-1:0] div_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_sync_q <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], osc_clk};
        end
    end

    // level changes only when the later two stages agree
    wire logic osc_agree = (osc_sync_q[1] == osc_sync_q[2]);
    wire logic osc_rise  = osc_agree && osc_sync_q[2] && !osc_lvl_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_lvl_q <= 1'b0;
            div_q     <= '0;
        end else begin
            if (osc_agree) begin
                osc_lvl_q <= osc_sync_q[2];
            end
            if (osc_rise && !osc_halt_q) begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // code 1 raw, code k taps bit k-1
    logic wave_lvl;
    always_comb begin
        wave_lvl = 1'b1;
        if (wave_rate_select_q == 4'h1) begin
            wave_lvl = osc_lvl_q;
        end else if (wave_rate_select_q != 4'h0) begin
            wave_lvl = div_q[4'(wave_rate_select_q - 4'h2) + 4'h1];
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // pointer on flag register masks interrupt
    wire logic irq_on = alarm_match_flag_q && alarm_irq_enable &&
                        (reg_ptr != FLAGS_ADDR);

    wire logic mfo_low =
        square_wave_enable ? (!wave_lvl && !osc_halt_q) :
        alarm_irq_enable   ? irq_on :
        !output_level_bit_q;

    // only enable and halt stop it
    wire logic fixed_32k_output_low = fixed_output_enable_q && !osc_halt_q && !osc_lvl_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mfo_q  <= '{o: 1'b0, oe: 1'b0};
            fixed_32k_output_q <= '{o: 1'b0, oe: 1'b0};
        end else begin
            mfo_q  <= '{o: 1'b0, oe: mfo_low};
            fixed_32k_output_q <= '{o: 1'b0, oe: fixed_32k_output_low};
        end
    end

    assign reg_rdata             = rdata_q;
    assign reg_rvalid            = rvalid_q;
    assign osc_halt              = osc_halt_q;
    assign multi_function_output = mfo_q;
    assign fixed_32k_output      = fixed_32k_output_q;

endmodule : rtc_alarm_sqw_output_logic

// >>> tb/rtc_host_model.sv
// Purpose: host side of the register port, standing in for the serial engine
// Assumes: one byte per strobe, read answer one cycle after the strobe
// Notes:   pointer rests on the last address used
`timescale 1ns/10ps
module rtc_host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] reg_ptr,
    output logic            reg_wr_stb,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd_stb,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial {reg_ptr, reg_wr_stb, reg_wdata, reg_rd_stb} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_ptr, reg_wdata, reg_wr_stb} = {a, d, 1'b1};
        @(negedge clk);
        // data not held once taken, so a stale byte cannot pass
        {reg_wdata, reg_wr_stb} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {reg_ptr, reg_rd_stb} = {a, 1'b1};
        @(negedge clk);
        reg_rd_stb = 1'b0;
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask : rd
endmodule : rtc_host_model

// >>> tb/rtc_alarm_sqw_output_logic_sva.sv
// Purpose: concurrent checks on register answers and output pins
// Assumes: strobe register port, one answer per read strobe
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module rtc_alarm_sva
    import rtc_alarm_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_ptr,
    input wire logic       reg_wr_stb,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // calendar and pins
    input wire logic       time_update,
    input wire logic       osc_halt,
    input wire od_pin_t    multi_function_output,
    input wire od_pin_t    fixed_32k_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_flag_rd;
        reg_rd_stb && reg_ptr == FLAGS_ADDR && !time_update;
    endsequence
    sequence s_halt_wr;
        reg_wr_stb && reg_ptr == SECONDS_ADDR && reg_wdata[HALT_BIT];
    endsequence
    property p_rd_answer; reg_rd_stb |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_flag_clear;
        s_flag_rd ##1 !time_update ##1 s_flag_rd |=> reg_rdata == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_flag_bits;
        reg_rvalid && $past(reg_ptr) == FLAGS_ADDR |-> (reg_rdata & 8'hBF) == 8'h00;
    endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("flag byte bad");
    property p_rate_low;
        reg_rvalid && $past(reg_ptr) == WAVE_ADDR |-> reg_rdata[3:0] == 4'h0;
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("rate low bits set");
    property p_halt_set; s_halt_wr |-> ##[1:2] osc_halt; endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt not taken");
    property p_halt_off; osc_halt [*2] |-> !fixed_32k_output.oe; endproperty
    a_halt_off: assert property (p_halt_off) else $error("fixed pin runs halted");
    property p_od; !multi_function_output.o && !fixed_32k_output.o; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_power_up;
        $fell(sys_rst) |-> !multi_function_output.oe && !osc_halt;
    endproperty
    a_power_up: assert property (p_power_up) else $error("bad power-up state");
endmodule : rtc_alarm_sva

bind rtc_alarm_sqw_output_logic rtc_alarm_sva u_sva (.clk(clk), .sys_rst(sys_rst),
    .reg_ptr(reg_ptr), .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata),
    .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .time_update(time_update), .osc_halt(osc_halt),
    .multi_function_output(multi_function_output), .fixed_32k_output(fixed_32k_output));

// >>> tb/test_rtc_alarm_sqw_output_logic.sv
// Purpose: directed scenarios for the alarm, wave and output block
// Assumes: host model drives the register port
// Notes:   only fast wave rates are timed, to keep the run short
`timescale 1ns/10ps
module test_rtc_alarm_sqw_output_logic
    import rtc_alarm_pkg::*;
;
    logic       clk, sys_rst, osc_clk, time_update, century_rollover, osc_halt;
    logic       reg_wr_stb, reg_rd_stb, reg_rvalid;
    logic [7:0] reg_ptr, reg_wdata, reg_rdata, rv;
    cal_time_t  cur_time;
    od_pin_t    mfo, f32;
    int         err_total, compares, n;

    rtc_alarm_sqw_output_logic DUT (.clk(clk), .sys_rst(sys_rst), .osc_clk(osc_clk),
        .reg_ptr(reg_ptr), .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata),
        .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cur_time(cur_time), .time_update(time_update),
        .century_rollover(century_rollover), .osc_halt(osc_halt),
        .multi_function_output(mfo), .fixed_32k_output(f32));
    rtc_host_model host (.clk(clk), .reg_ptr(reg_ptr), .reg_wr_stb(reg_wr_stb),
        .reg_wdata(reg_wdata), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        osc_clk = 1'b0;
        #3;
        forever #80 osc_clk = ~osc_clk;
    end
    task automatic summarize;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk(s, e, rv);
    endtask : rchk
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // w marks fields that differ from the alarm: bit0 sec up to bit4 month
    task automatic pulse(input logic [4:0] w);
        @(negedge clk);
        cur_time = {w[4] ? 5'h01 : 5'h12, w[3] ? 6'h01 : 6'h25, w[2] ? 6'h01 : 6'h23,
                    w[1] ? 7'h01 : 7'h59, w[0] ? 7'h01 : 7'h58};
        time_update = 1'b1;
        @(negedge clk);
        time_update = 1'b0;
    endtask : pulse
    task automatic roll;
        @(negedge clk);
        century_rollover = 1'b1;
        @(negedge clk);
        century_rollover = 1'b0;
    endtask : roll
    task automatic arm(input logic [4:0] r, input logic [7:0] ctl);
        host.wr(ALARM_MONTH_ADDR, ctl);
        host.wr(ALARM_DATE_ADDR, {r[3], r[4], 6'h25});
        host.wr(ALARM_HOUR_ADDR, {r[2], 7'h23});
        host.wr(ALARM_MIN_ADDR, {r[1], 7'h59});
        host.wr(ALARM_SEC_ADDR, {r[0], 7'h58});
    endtask : arm
    task automatic lvl(input logic v, inout int c);
        for (int i = 0; i < 300 && mfo.oe !== v; i++) begin
            @(negedge clk);
            c++;
        end
        if (mfo.oe !== v) begin
            chk("pin edge", {7'h0, v}, {7'h0, mfo.oe});
            summarize();
        end
    endtask : lvl
    task automatic fcnt(output int c);
        c = 0;
        cyc(4);
        repeat (64) begin
            @(negedge clk);
            // unknown counts as pulling so it cannot pass as off
            if (f32.oe !== 1'b0) c++;
        end
    endtask : fcnt
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic acase(input logic [4:0] r, input logic [4:0] w, input logic x);
        arm(r, 8'h92);
        pulse(w);
        cyc(2);
        chk("irq", {7'h0, x}, {7'h0, mfo.oe});
        rchk("flag", FLAGS_ADDR, {1'b0, x, 6'h0});
        chk("irq off", 8'h00, {7'h0, mfo.oe});
        rchk("flag 2nd", FLAGS_ADDR, 8'h00);
    endtask : acase
    task automatic t_repeat;
        logic [4:0] codes [6] = '{RPT_SECOND, RPT_MINUTE, RPT_HOUR, RPT_DAY, RPT_MONTH,
                                  RPT_YEAR};
        for (int i = 0; i < 6; i++) begin
            acase(codes[i], 5'h1F << i, 1'b1);
            if (i > 0) acase(codes[i], 5'h01 << (i - 1), 1'b0);
        end
        acase(5'h15, 5'h1F, 1'b1);
        rchk("al hour", ALARM_HOUR_ADDR, 8'hA3);
    endtask : t_repeat
    task automatic t_hold;
        arm(RPT_SECOND, 8'h92);
        host.rd(FLAGS_ADDR, rv);
        pulse(5'h1F);
        cyc(3);
        chk("irq held", 8'h00, {7'h0, mfo.oe});
        host.rd(OUTPUT_CONTROL_ADDR, rv);
        cyc(2);
        chk("irq moved", 8'h01, {7'h0, mfo.oe});
        host.wr(FLAGS_ADDR, 8'h00);
        rchk("flag wr", FLAGS_ADDR, 8'h40);
        rchk("flag 2nd", FLAGS_ADDR, 8'h00);
    endtask : t_hold
    task automatic t_level;
        rchk("ctrl", OUTPUT_CONTROL_ADDR, 8'h80);
        rchk("fixed", FIXED_OUT_ADDR, 8'h80);
        rchk("al ctl", ALARM_MONTH_ADDR, 8'h00);
        chk("halt rst", 8'h00, {7'h0, osc_halt});
        chk("level", 8'h00, {7'h0, mfo.oe});
        host.wr(OUTPUT_CONTROL_ADDR, 8'h00);
        fcnt(n);
        chk("level low", 8'h01, {7'h0, mfo.oe});
        chk("f32 kept", 8'h20, 8'(n));
        host.wr(OUTPUT_CONTROL_ADDR, 8'h80);
        cyc(2);
        chk("level rel", 8'h00, {7'h0, mfo.oe});
    endtask : t_level
    task automatic t_wave;
        arm(RPT_SECOND, 8'hD2);
        pulse(5'h1F);
        cyc(3);
        chk("no wave", 8'h00, {7'h0, mfo.oe});
        for (int k = 1; k < 4; k++) begin
            host.wr(WAVE_ADDR, 8'(k << 4));
            rchk("rate", WAVE_ADDR, 8'(k << 4));
            n = 0;
            lvl(1'b0, n);
            lvl(1'b1, n);
            n = 0;
            lvl(1'b0, n);
            lvl(1'b1, n);
            chk("period", k == 1 ? 8'h10 : 8'(8'h10 << k), 8'(n));
        end
        host.wr(ALARM_MONTH_ADDR, 8'h12);
        rchk("flag kept", FLAGS_ADDR, 8'h40);
        rchk("flag 2nd", FLAGS_ADDR, 8'h00);
    endtask : t_wave
    task automatic t_fixed;
        fcnt(n);
        chk("f32 run", 8'h20, 8'(n));
        host.wr(FIXED_OUT_ADDR, 8'h00);
        fcnt(n);
        chk("f32 off", 8'h00, 8'(n));
        host.wr(FIXED_OUT_ADDR, 8'h80);
        host.wr(SECONDS_ADDR, 8'h80);
        fcnt(n);
        chk("f32 halt", 8'h00, 8'(n));
        chk("halt", 8'h01, {7'h0, osc_halt});
        host.wr(SECONDS_ADDR, 8'h00);
        fcnt(n);
        chk("f32 back", 8'h20, 8'(n));
    endtask : t_fixed
    task automatic t_century;
        host.wr(CENTURY_HOURS_ADDR, 8'h80);
        roll();
        rchk("cent on", CENTURY_HOURS_ADDR, {2'b11, cur_time.hour});
        host.wr(CENTURY_HOURS_ADDR, 8'h40);
        roll();
        rchk("cent off", CENTURY_HOURS_ADDR, {2'b01, cur_time.hour});
    endtask : t_century

    initial begin
        #900000;
        err_total++;
        summarize();
    end
    initial begin
        {sys_rst, time_update, century_rollover} = 3'b100;
        cur_time = '0;
        err_total = 0;
        compares = 0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        t_level();
        t_repeat();
        t_hold();
        t_wave();
        t_fixed();
        t_century();
        summarize();
    end
endmodule : test_rtc_alarm_sqw_output_logic
